//--- verilog/local_peripheral.sv
// local bus party: eight-word slave plus a hold-requesting master
`timescale 1ns/1ps
module local_peripheral (
	input wire logic CLK,
	input wire logic RST,
	input wire logic USER_REQ,
	input wire logic [31:0] USER_ADDR,
	input wire logic USER_READ_NOT_WRITE,
	input wire logic [3:0] USER_BYTE_EN_N,
	input wire logic [31:0] USER_WDATA,
	input wire logic SLAVE_RETRY,
	output logic USER_DONE,
	output logic USER_RETRIED,
	output logic [31:0] USER_RDATA,
	lbus_if.periph_end LBUS
);
	lbus_pkg::slv_state_t sl_r;
	lbus_pkg::mst_state_t ms_r;
	logic [73:0] sync1_r;
	logic [73:0] sync2_r;
	logic lclk_d_r;
	logic [2:0] sl_cnt_r;
	logic [2:0] sl_idx_r;
	logic sl_rnw_r;
	logic [3:0] sl_be_n_r;
	logic [31:0] sl_wdata_r;
	logic sl_ready_n_r;
	logic sl_retry_n_r;
	logic sl_rdy_oe_n_r;
	logic sl_data_oe_n_r;
	logic [31:0] sl_data_r;
	logic [31:0] m_addr_r;
	logic [3:0] m_be_n_r;
	logic m_rnw_r;
	logic [31:0] m_wdata_r;
	logic m_ads_n_r;
	logic m_ctl_oe_n_r;
	logic m_data_oe_n_r;
	logic m_hold_r;
	logic m_armed_r;
	logic [31:0] m_rdata_r;
	logic m_retried_r;
	logic [31:0] rd_word;

	wire logic [73:0] pin_in = {LBUS.local_bus_clock, LBUS.local_addr_strobe_n, LBUS.local_read_not_write,
		LBUS.local_byte_en_n, LBUS.local_addr, LBUS.local_data, LBUS.local_ready_n, LBUS.local_retry_n,
		LBUS.local_hold_ack};
	localparam logic [73:0] SYNC_RST = {3'b011, 4'hf, 32'h0, 32'h0, 3'b110};

	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
			lclk_d_r <= 1'b0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			lclk_d_r <= sync2_r[73];
		end
	end

	wire logic rise = sync2_r[73] && !lclk_d_r;
	wire logic ads_s_n = sync2_r[72];
	wire logic rnw_s = sync2_r[71];
	wire logic [3:0] be_s_n = sync2_r[70:67];
	wire logic [31:0] addr_s = sync2_r[66:35];
	wire logic [31:0] data_s = sync2_r[34:3];
	wire logic ready_s_n = sync2_r[2];
	wire logic retry_s_n = sync2_r[1];
	wire logic ack_s = sync2_r[0];

	// slave side
	wire logic window = addr_s[31:5] == lbus_pkg::SLAVE_BASE[31:5];
	// answers any master, own master included, so a converter write is served while a grant is pending
	wire logic hit = rise && !ads_s_n && window && (sl_r == lbus_pkg::SL_IDLE);
	wire logic answer = rise && (sl_r == lbus_pkg::SL_WAIT) && (sl_cnt_r == lbus_pkg::SLAVE_WAIT - 3'h1);
	wire logic store = answer && !sl_rnw_r && !SLAVE_RETRY;

	genvar b;
	generate
		for (b = 0; b < lbus_pkg::BE_W; b++) begin : g_lane
			logic [7:0] lane_r [0:7];
			always_ff @(posedge CLK) begin
				if (store && !sl_be_n_r[b]) begin
					lane_r[sl_idx_r] <= sl_wdata_r[8*b +: 8];
				end
			end
			assign rd_word[8*b +: 8] = lane_r[sl_idx_r];
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (RST) begin
			sl_r <= lbus_pkg::SL_IDLE;
			sl_cnt_r <= 3'h0;
			sl_idx_r <= 3'h0;
			sl_rnw_r <= 1'b1;
			sl_be_n_r <= 4'hf;
			sl_wdata_r <= 32'h0;
		end else begin
			case (sl_r)
				lbus_pkg::SL_IDLE: begin
					if (hit) begin
						sl_r <= lbus_pkg::SL_WAIT;
						sl_cnt_r <= 3'h0;
						sl_idx_r <= addr_s[4:2];
						sl_rnw_r <= rnw_s;
						sl_be_n_r <= be_s_n;
						sl_wdata_r <= data_s;
					end
				end
				lbus_pkg::SL_WAIT: begin
					if (answer) begin
						sl_r <= lbus_pkg::SL_ANSWER;
					end else if (rise) begin
						sl_cnt_r <= sl_cnt_r + 3'h1;
					end
				end
				lbus_pkg::SL_ANSWER: begin
					if (rise) begin
						sl_r <= lbus_pkg::SL_IDLE;
					end
				end
				default: begin
					sl_r <= lbus_pkg::SL_IDLE;
				end
			endcase
		end
	end

	// ready or retry held for one local clock period, read data with it
	always_ff @(posedge CLK) begin
		if (RST) begin
			sl_ready_n_r <= 1'b1;
			sl_retry_n_r <= 1'b1;
			sl_rdy_oe_n_r <= 1'b1;
			sl_data_oe_n_r <= 1'b1;
			sl_data_r <= 32'h0;
		end else if (answer) begin
			sl_ready_n_r <= SLAVE_RETRY;
			sl_retry_n_r <= !SLAVE_RETRY;
			sl_rdy_oe_n_r <= 1'b0;
			sl_data_oe_n_r <= !sl_rnw_r;
			sl_data_r <= rd_word;
		end else if (rise && sl_r == lbus_pkg::SL_ANSWER) begin
			sl_ready_n_r <= 1'b1;
			sl_retry_n_r <= 1'b1;
			sl_rdy_oe_n_r <= 1'b1;
			sl_data_oe_n_r <= 1'b1;
		end
	end

	// master side
	wire logic m_take = (ms_r == lbus_pkg::MS_IDLE) && USER_REQ && !ack_s;
	wire logic m_go = (ms_r == lbus_pkg::MS_HOLD) && ack_s && rise;
	wire logic m_end = (ms_r == lbus_pkg::MS_WAIT) && m_armed_r && (!ready_s_n || !retry_s_n);

	always_ff @(posedge CLK) begin
		if (RST) begin
			ms_r <= lbus_pkg::MS_IDLE;
			m_addr_r <= 32'h0;
			m_be_n_r <= 4'hf;
			m_rnw_r <= 1'b1;
			m_wdata_r <= 32'h0;
		end else begin
			case (ms_r)
				lbus_pkg::MS_IDLE: begin
					if (m_take) begin
						ms_r <= lbus_pkg::MS_HOLD;
						m_addr_r <= USER_ADDR;
						m_be_n_r <= USER_BYTE_EN_N;
						m_rnw_r <= USER_READ_NOT_WRITE;
						m_wdata_r <= USER_WDATA;
					end
				end
				lbus_pkg::MS_HOLD: begin
					if (m_go) begin
						ms_r <= lbus_pkg::MS_STROBE;
					end
				end
				lbus_pkg::MS_STROBE: begin
					if (rise) begin
						ms_r <= lbus_pkg::MS_WAIT;
					end
				end
				lbus_pkg::MS_WAIT: begin
					if (m_end) begin
						ms_r <= lbus_pkg::MS_DONE;
					end
				end
				lbus_pkg::MS_DONE: begin
					ms_r <= lbus_pkg::MS_IDLE;
				end
				default: begin
					ms_r <= lbus_pkg::MS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			m_hold_r <= 1'b0;
			m_ads_n_r <= 1'b1;
			m_ctl_oe_n_r <= 1'b1;
			m_data_oe_n_r <= 1'b1;
			m_armed_r <= 1'b0;
			m_rdata_r <= 32'h0;
			m_retried_r <= 1'b0;
		end else begin
			if (m_take) begin
				m_hold_r <= 1'b1;
			end else if (m_end) begin
				m_hold_r <= 1'b0;
			end
			if (m_go) begin
				m_ads_n_r <= 1'b0;
				m_ctl_oe_n_r <= 1'b0;
				m_data_oe_n_r <= m_rnw_r;
			end else if (ms_r == lbus_pkg::MS_STROBE && rise) begin
				m_ads_n_r <= 1'b1;
			end else if (m_end) begin
				m_ctl_oe_n_r <= 1'b1;
				m_data_oe_n_r <= 1'b1;
			end
			if (m_go) begin
				m_armed_r <= 1'b0;
			end else if (ready_s_n && retry_s_n) begin
				m_armed_r <= 1'b1;
			end
			if (m_end) begin
				m_retried_r <= ready_s_n;
				m_rdata_r <= data_s;
			end
		end
	end

	assign LBUS.local_hold_request = m_hold_r;
	assign LBUS.pe_addr = m_addr_r;
	assign LBUS.pe_be_n = m_be_n_r;
	assign LBUS.pe_ads_n = m_ads_n_r;
	assign LBUS.pe_rnw = m_rnw_r;
	assign LBUS.pe_ctl_oe_n = m_ctl_oe_n_r;
	assign LBUS.pe_data = !sl_data_oe_n_r ? sl_data_r : m_wdata_r;
	assign LBUS.pe_data_oe_n = sl_data_oe_n_r && m_data_oe_n_r;
	assign LBUS.pe_ready_n = sl_ready_n_r;
	assign LBUS.pe_retry_n = sl_retry_n_r;
	assign LBUS.pe_rdy_oe_n = sl_rdy_oe_n_r;
	assign USER_DONE = (ms_r == lbus_pkg::MS_DONE);
	assign USER_RETRIED = m_retried_r;
	assign USER_RDATA = m_rdata_r;
endmodule : local_peripheral

//--- verilog/lbus_pkg.sv
// shared constants and state types for the system-to-local bus converter and its local partner
package lbus_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	// lowest physical address forwarded to the local bus; the range runs to the top of memory
	localparam logic [31:0] LOCAL_SPACE_BASE = 32'h1100_0000;
	localparam logic [31:0] LOCAL_SPACE_TOP = 32'hffff_ffff;
	// watchdog span in system clock cycles
	localparam logic [8:0] WD_LIMIT = 9'h100;
	// local peripheral: eight-word window and answer delay in local clock periods
	localparam logic [31:0] SLAVE_BASE = 32'h1100_0000;
	localparam int SLAVE_IDX_W = 3;
	localparam logic [2:0] SLAVE_WAIT = 3'h2;
	localparam logic [1:0] DIV_CNT_RST = 2'h0;

	typedef enum logic [4:0] {
		CV_IDLE = 5'b00001,
		CV_PEND = 5'b00010,
		CV_STROBE = 5'b00100,
		CV_WAIT = 5'b01000,
		CV_DONE = 5'b10000
	} conv_state_t;

	typedef enum logic [2:0] {
		SL_IDLE = 3'b001,
		SL_WAIT = 3'b010,
		SL_ANSWER = 3'b100
	} slv_state_t;

	typedef enum logic [4:0] {
		MS_IDLE = 5'b00001,
		MS_HOLD = 5'b00010,
		MS_STROBE = 5'b00100,
		MS_WAIT = 5'b01000,
		MS_DONE = 5'b10000
	} mst_state_t;
endpackage : lbus_pkg

//--- verilog/lbus_if.sv
// local bus wires between the converter end and the local peripheral end
`timescale 1ns/1ps
interface lbus_if;
	logic local_bus_clock;
	logic local_hold_request;
	logic local_hold_ack;
	// converter drivers, enables active low
	logic [31:0] cv_addr;
	logic [3:0] cv_be_n;
	logic cv_ads_n;
	logic cv_rnw;
	logic cv_ctl_oe_n;
	logic [31:0] cv_data;
	logic cv_data_oe_n;
	// peripheral drivers, enables active low
	logic [31:0] pe_addr;
	logic [3:0] pe_be_n;
	logic pe_ads_n;
	logic pe_rnw;
	logic pe_ctl_oe_n;
	logic [31:0] pe_data;
	logic pe_data_oe_n;
	logic pe_ready_n;
	logic pe_retry_n;
	logic pe_rdy_oe_n;
	// resolved wire levels; undriven strobes float high, data low
	logic [31:0] local_addr;
	logic [3:0] local_byte_en_n;
	logic local_addr_strobe_n;
	logic local_read_not_write;
	logic [31:0] local_data;
	logic local_ready_n;
	logic local_retry_n;

	assign local_addr = !cv_ctl_oe_n ? cv_addr : (!pe_ctl_oe_n ? pe_addr : 32'h0);
	assign local_byte_en_n = !cv_ctl_oe_n ? cv_be_n : (!pe_ctl_oe_n ? pe_be_n : 4'hf);
	assign local_addr_strobe_n = !cv_ctl_oe_n ? cv_ads_n : (!pe_ctl_oe_n ? pe_ads_n : 1'b1);
	assign local_read_not_write = !cv_ctl_oe_n ? cv_rnw : (!pe_ctl_oe_n ? pe_rnw : 1'b1);
	assign local_data = !cv_data_oe_n ? cv_data : (!pe_data_oe_n ? pe_data : 32'h0);
	assign local_ready_n = !pe_rdy_oe_n ? pe_ready_n : 1'b1;
	assign local_retry_n = !pe_rdy_oe_n ? pe_retry_n : 1'b1;

	modport conv_end (
		output local_bus_clock,
		output local_hold_ack,
		output cv_addr,
		output cv_be_n,
		output cv_ads_n,
		output cv_rnw,
		output cv_ctl_oe_n,
		output cv_data,
		output cv_data_oe_n,
		input local_hold_request,
		input local_data,
		input local_ready_n,
		input local_retry_n
	);

	modport periph_end (
		output local_hold_request,
		output pe_addr,
		output pe_be_n,
		output pe_ads_n,
		output pe_rnw,
		output pe_ctl_oe_n,
		output pe_data,
		output pe_data_oe_n,
		output pe_ready_n,
		output pe_retry_n,
		output pe_rdy_oe_n,
		input local_bus_clock,
		input local_hold_ack,
		input local_addr,
		input local_byte_en_n,
		input local_addr_strobe_n,
		input local_read_not_write,
		input local_data,
		input local_ready_n,
		input local_retry_n
	);
endinterface : lbus_if

//--- verilog/clock_divider.sv
// local bus clock generator: system clock divided by 2 or 4
`timescale 1ns/1ps
module clock_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic halve_n,
	output logic lclk,
	output logic rise
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic lclk_r;
	logic lclk_nxt;

	assign cnt_nxt = cnt_r + 2'h1;
	// low select halves, high quarters
	assign lclk_nxt = !halve_n ? cnt_nxt[0] : cnt_nxt[1];
	// true in the cycle whose closing edge raises the local clock
	assign rise = lclk_nxt && !lclk_r;
	assign lclk = lclk_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= lbus_pkg::DIV_CNT_RST;
			lclk_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			lclk_r <= lclk_nxt;
		end
	end
endmodule : clock_divider

//--- verilog/bus_converter.sv
// system bus to local bus converter: local master, hold arbiter, clock source and watchdog
// Functional notes
// - separate 32-bit address and data paths
// - memory transfers only, no I/O or acknowledge
// - single transfers only, never bursts
// - ownership via hold request and hold acknowledge
// - retry input may end a transfer
// - start transfers only while hold acknowledge low
// - device transfers only after hold acknowledge
// - strobe with valid address and byte enables
// - direction valid together with the strobe
// - write data valid from the strobe
// - slave readies; master holds signals until then
// - read data valid by the ready cycle
// - forward addresses 0x11000000 to 0xffffffff
// - answer within 256 cycles or bus error
// - align to local clock before the strobe
// - launch write data on local rising edge
// - system ready the cycle after local ready; the code answers three cycles after, past the two sync flops
// - width request together with system ready
// - capture read data with sampled ready
// - watchdog counts from start strobe to answer
`timescale 1ns/1ps
module bus_converter (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CLOCK_HALVE_SELECT_N,
	input wire logic SYS_TXN_START_STROBE_N,
	input wire logic [31:0] SYS_ADDR,
	input wire logic SYS_READ_NOT_WRITE,
	input wire logic [3:0] SYS_BYTE_EN_N,
	input wire logic [31:0] SYS_WDATA,
	input wire logic SYS_EXT_ANSWER_N,
	output logic [31:0] SYS_RDATA,
	output logic SYS_BUS_READY_N,
	output logic SYS_BUS_WIDTH_REQUEST_N,
	output logic SYS_BUS_RETRY_N,
	output logic SYS_BUS_ERROR_N,
	lbus_if.conv_end LBUS
);
	lbus_pkg::conv_state_t state_r;
	lbus_pkg::conv_state_t state_nxt;
	logic [34:0] sync1_r;
	logic [34:0] sync2_r;
	logic lclk;
	logic lclk_rise;
	logic [31:0] addr_r;
	logic [3:0] be_n_r;
	logic rnw_r;
	logic [31:0] wdata_r;
	logic [31:0] data_out_r;
	logic ads_n_r;
	logic data_oe_n_r;
	logic ack_r;
	logic armed_r;
	logic retry_hit_r;
	logic [31:0] rdata_r;
	logic wd_run_r;
	logic [8:0] wd_cnt_r;

	// pins from the far party pass two flops; data travels with ready so they stay aligned
	wire logic [34:0] pin_in = {LBUS.local_ready_n, LBUS.local_retry_n, LBUS.local_hold_request, LBUS.local_data};
	wire logic ready_s_n = sync2_r[34];
	wire logic retry_s_n = sync2_r[33];
	wire logic hold_s = sync2_r[32];
	wire logic [31:0] rdata_s = sync2_r[31:0];

	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1_r <= {3'b110, 32'h0};
			sync2_r <= {3'b110, 32'h0};
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	clock_divider u_div (
		.clk(CLK),
		.rst(RST),
		.halve_n(CLOCK_HALVE_SELECT_N),
		.lclk(lclk),
		.rise(lclk_rise)
	);
	assign LBUS.local_bus_clock = lclk;

	wire logic start = !SYS_TXN_START_STROBE_N;
	wire logic in_range = (SYS_ADDR >= lbus_pkg::LOCAL_SPACE_BASE) && (SYS_ADDR <= lbus_pkg::LOCAL_SPACE_TOP);
	wire logic take = start && in_range && (state_r == lbus_pkg::CV_IDLE);
	wire logic launch = (state_r == lbus_pkg::CV_PEND) && lclk_rise && !ack_r;
	wire logic answered_loc = !ready_s_n || !retry_s_n;
	wire logic finish = (state_r == lbus_pkg::CV_WAIT) && armed_r && answered_loc;
	wire logic sys_answer = (state_r == lbus_pkg::CV_DONE) || !SYS_EXT_ANSWER_N;
	wire logic wd_fire = wd_run_r && (wd_cnt_r == lbus_pkg::WD_LIMIT - 9'h1) && !sys_answer;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lbus_pkg::CV_IDLE: begin
				if (take) begin
					state_nxt = lbus_pkg::CV_PEND;
				end
			end
			lbus_pkg::CV_PEND: begin
				if (wd_fire) begin
					state_nxt = lbus_pkg::CV_IDLE;
				end else if (launch) begin
					state_nxt = lbus_pkg::CV_STROBE;
				end
			end
			lbus_pkg::CV_STROBE: begin
				// strobe spans exactly one local clock period
				if (wd_fire) begin
					state_nxt = lbus_pkg::CV_IDLE;
				end else if (lclk_rise) begin
					state_nxt = lbus_pkg::CV_WAIT;
				end
			end
			lbus_pkg::CV_WAIT: begin
				if (wd_fire) begin
					state_nxt = lbus_pkg::CV_IDLE;
				end else if (finish) begin
					state_nxt = lbus_pkg::CV_DONE;
				end
			end
			lbus_pkg::CV_DONE: begin
				state_nxt = lbus_pkg::CV_IDLE;
			end
			default: begin
				state_nxt = lbus_pkg::CV_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= lbus_pkg::CV_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// request latched once; the bus sees it unchanged until the answer
	always_ff @(posedge CLK) begin
		if (RST) begin
			addr_r <= 32'h0;
			be_n_r <= 4'hf;
			rnw_r <= 1'b1;
			wdata_r <= 32'h0;
		end else if (take) begin
			addr_r <= SYS_ADDR;
			be_n_r <= SYS_BYTE_EN_N;
			rnw_r <= SYS_READ_NOT_WRITE;
			wdata_r <= SYS_WDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ads_n_r <= 1'b1;
			data_oe_n_r <= 1'b1;
			data_out_r <= 32'h0;
		end else if (launch) begin
			ads_n_r <= 1'b0;
			data_oe_n_r <= rnw_r;
			data_out_r <= wdata_r;
		end else begin
			if (wd_fire || (state_r == lbus_pkg::CV_STROBE && lclk_rise)) begin
				ads_n_r <= 1'b1;
			end
			if (wd_fire || finish) begin
				data_oe_n_r <= 1'b1;
			end
		end
	end

	// stale ready from the previous transfer must be seen released first
	always_ff @(posedge CLK) begin
		if (RST) begin
			armed_r <= 1'b0;
		end else if (launch) begin
			armed_r <= 1'b0;
		end else if (ready_s_n && retry_s_n) begin
			armed_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			retry_hit_r <= 1'b0;
			rdata_r <= 32'h0;
		end else if (finish) begin
			retry_hit_r <= ready_s_n;
			if (rnw_r) begin
				rdata_r <= rdata_s;
			end
		end
	end

	// grant only from idle, so an open transfer always completes first
	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_r <= 1'b0;
		end else if (!hold_s) begin
			ack_r <= 1'b0;
		end else if (state_r == lbus_pkg::CV_IDLE && !(start && in_range)) begin
			ack_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			wd_run_r <= 1'b0;
			wd_cnt_r <= 9'h0;
		end else if (start) begin
			wd_run_r <= 1'b1;
			wd_cnt_r <= 9'h0;
		end else if (sys_answer || wd_fire) begin
			wd_run_r <= 1'b0;
		end else if (wd_run_r) begin
			wd_cnt_r <= wd_cnt_r + 9'h1;
		end
	end

	assign LBUS.local_hold_ack = ack_r;
	assign LBUS.cv_ctl_oe_n = ack_r;
	assign LBUS.cv_addr = addr_r;
	assign LBUS.cv_be_n = be_n_r;
	assign LBUS.cv_rnw = rnw_r;
	assign LBUS.cv_ads_n = ads_n_r;
	assign LBUS.cv_data = data_out_r;
	assign LBUS.cv_data_oe_n = data_oe_n_r;

	wire logic done = (state_r == lbus_pkg::CV_DONE);
	assign SYS_BUS_READY_N = !(done && !retry_hit_r);
	assign SYS_BUS_WIDTH_REQUEST_N = !(done && !retry_hit_r);
	assign SYS_BUS_RETRY_N = !(done && retry_hit_r);
	assign SYS_BUS_ERROR_N = !wd_fire;
	assign SYS_RDATA = rdata_r;
endmodule : bus_converter

//--- testbench/bus_converter_props.sv
// concurrent checks on the converter's system answers and its local bus wires
`timescale 1ns/1ps
module bus_converter_props (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SYS_BUS_READY_N,
	input wire logic SYS_BUS_WIDTH_REQUEST_N,
	input wire logic SYS_BUS_RETRY_N,
	input wire logic SYS_BUS_ERROR_N,
	input wire logic local_bus_clock,
	input wire logic local_hold_request,
	input wire logic local_hold_ack,
	input wire logic cv_ads_n,
	input wire logic cv_rnw,
	input wire logic cv_ctl_oe_n,
	input wire logic [31:0] cv_data,
	input wire logic cv_data_oe_n,
	input wire logic local_ready_n
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_width_with_ready: assert property (SYS_BUS_WIDTH_REQUEST_N == SYS_BUS_READY_N)
		else $error("width request differs from ready");
	a_ready_after_local: assert property (!SYS_BUS_READY_N |-> !$past(local_ready_n, 2) || !$past(local_ready_n, 3))
		else $error("system ready without recent local ready");
	a_ready_one_cycle: assert property (!SYS_BUS_READY_N |=> SYS_BUS_READY_N)
		else $error("system ready longer than one cycle");
	a_retry_not_ready: assert property (!SYS_BUS_RETRY_N |-> SYS_BUS_READY_N && SYS_BUS_ERROR_N)
		else $error("retry together with another answer");
	a_error_alone: assert property (!SYS_BUS_ERROR_N |-> SYS_BUS_READY_N && SYS_BUS_RETRY_N)
		else $error("error together with another answer");
	a_no_strobe_granted: assert property (local_hold_ack |-> cv_ads_n && cv_ctl_oe_n)
		else $error("converter strobes or drives while granted");
	a_strobe_on_rise: assert property ($fell(cv_ads_n) |-> $rose(local_bus_clock))
		else $error("strobe not aligned to local clock rise");
	a_write_data_out: assert property (!cv_ads_n && !cv_rnw |-> !cv_data_oe_n)
		else $error("write strobe without driven data");
	a_data_held: assert property (!cv_data_oe_n && !$past(cv_data_oe_n) |-> $stable(cv_data))
		else $error("write data changed before ready");
	a_grant_after_req: assert property ($rose(local_hold_ack) |-> $past(local_hold_request, 3))
		else $error("hold ack without hold request");
	a_grant_release: assert property ($fell(local_hold_request) |-> ##3 !local_hold_ack)
		else $error("hold ack not withdrawn");
	c_ready: cover property (!SYS_BUS_READY_N);
	c_retry: cover property (!SYS_BUS_RETRY_N);
	c_error: cover property (!SYS_BUS_ERROR_N);
	c_grant: cover property ($rose(local_hold_ack));
endmodule : bus_converter_props

//--- testbench/test_bus_converter.sv
// self-checking bench: converter and local peripheral joined by the local bus
`timescale 1ns/1ps
module test_bus_converter;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic halve_n = 1'b0;
	logic start_n = 1'b1;
	logic [31:0] s_addr = 32'h0;
	logic s_rnw = 1'b1;
	logic [3:0] s_be_n = 4'h0;
	logic [31:0] s_wdata = 32'h0;
	logic ext_n = 1'b1;
	logic [31:0] s_rdata;
	logic rdy_n, wid_n, rty_n, err_n, w_seen;
	logic u_req = 1'b0;
	logic [31:0] u_addr = 32'h0;
	logic u_rnw = 1'b1;
	logic [31:0] u_wdata = 32'h0;
	logic slv_rty = 1'b0;
	logic u_done, u_retried;
	logic [31:0] u_rdata;
	int miscompares = 0;
	int check_count = 0;
	int strobes = 0;
	int code, cyc, n0;
	lbus_if lb();
	always #20 CLK = ~CLK;
	always @(negedge lb.cv_ads_n) strobes++;
	bus_converter i_bus_converter (.CLK(CLK), .RST(RST), .CLOCK_HALVE_SELECT_N(halve_n), .SYS_TXN_START_STROBE_N(start_n),
		.SYS_ADDR(s_addr), .SYS_READ_NOT_WRITE(s_rnw), .SYS_BYTE_EN_N(s_be_n), .SYS_WDATA(s_wdata), .SYS_EXT_ANSWER_N(ext_n),
		.SYS_RDATA(s_rdata), .SYS_BUS_READY_N(rdy_n), .SYS_BUS_WIDTH_REQUEST_N(wid_n), .SYS_BUS_RETRY_N(rty_n),
		.SYS_BUS_ERROR_N(err_n), .LBUS(lb.conv_end));
	local_peripheral i_local_peripheral (.CLK(CLK), .RST(RST), .USER_REQ(u_req), .USER_ADDR(u_addr),
		.USER_READ_NOT_WRITE(u_rnw), .USER_BYTE_EN_N(4'h0), .USER_WDATA(u_wdata), .SLAVE_RETRY(slv_rty),
		.USER_DONE(u_done), .USER_RETRIED(u_retried), .USER_RDATA(u_rdata), .LBUS(lb.periph_end));
	bus_converter_props i_props (.CLK(CLK), .RST(RST), .SYS_BUS_READY_N(rdy_n), .SYS_BUS_WIDTH_REQUEST_N(wid_n),
		.SYS_BUS_RETRY_N(rty_n), .SYS_BUS_ERROR_N(err_n), .local_bus_clock(lb.local_bus_clock),
		.local_hold_request(lb.local_hold_request), .local_hold_ack(lb.local_hold_ack), .cv_ads_n(lb.cv_ads_n),
		.cv_rnw(lb.cv_rnw), .cv_ctl_oe_n(lb.cv_ctl_oe_n), .cv_data(lb.cv_data), .cv_data_oe_n(lb.cv_data_oe_n),
		.local_ready_n(lb.local_ready_n));

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic do_reset(input logic div);
		@(negedge CLK);
		RST = 1'b1;
		halve_n = div;
		repeat (4) @(negedge CLK);
		check({rdy_n, wid_n, rty_n, err_n, lb.local_hold_ack, lb.local_addr_strobe_n, lb.cv_data_oe_n, u_done},
			8'hf6, "idle outputs in reset");
		check(s_rdata, 32'h0, "read data in reset");
		RST = 1'b0;
	endtask : do_reset

	// rises of the local clock over 24 system cycles
	task automatic clk_ratio(input logic div);
		int rises;
		logic prev;
		rises = 0;
		prev = lb.local_bus_clock;
		for (int i = 0; i < 24; i++) begin
			@(negedge CLK);
			if (lb.local_bus_clock === 1'b1 && prev === 1'b0) rises++;
			prev = lb.local_bus_clock;
		end
		check(rises, div ? 32'h6 : 32'hc, "local clock rises");
	endtask : clk_ratio

	// code: 0 ready, 1 retry, 2 error, 3 none within lim; ext_at pulses the other-responder answer
	task automatic sys_op(input logic rnw, input logic [31:0] addr, input logic [31:0] wd, input int lim, input int ext_at);
		@(negedge CLK);
		start_n = 1'b0;
		s_rnw = rnw;
		s_addr = addr;
		s_wdata = wd;
		@(negedge CLK);
		start_n = 1'b1;
		code = 3;
		cyc = 0;
		while (code == 3 && cyc < lim) begin
			@(negedge CLK);
			cyc++;
			ext_n = (cyc == ext_at) ? 1'b0 : 1'b1;
			if (rdy_n === 1'b0) begin
				code = 0;
				w_seen = wid_n;
			end else if (rty_n === 1'b0) begin
				code = 1;
			end else if (err_n === 1'b0) begin
				code = 2;
			end
		end
		if (code == 3 && ext_at < 0) begin
			miscompares++;
			complete_run();
		end
	endtask : sys_op

	task automatic user_op(input logic rnw, input logic [31:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		// the synced grant of an earlier transfer must have dropped before a new request
		repeat (6) @(negedge CLK);
		u_req = 1'b1;
		u_rnw = rnw;
		u_addr = addr;
		u_wdata = wd;
		@(negedge CLK);
		u_req = 1'b0;
		while (u_done !== 1'b1 && n < 400) begin
			@(negedge CLK);
			n++;
		end
		if (n >= 400) begin
			miscompares++;
			complete_run();
		end
	endtask : user_op

	initial begin
		#4000000;
		miscompares++;
		complete_run();
	end

	initial begin
		for (int d = 0; d < 2; d++) begin
			do_reset(d[0]);
			clk_ratio(d[0]);
			sys_op(1'b0, 32'h1100_0004, 32'ha5a5_0000 + d, 400, -1);
			check(code, 0, "write answer");
			check(w_seen, 1'b0, "width request with ready");
			sys_op(1'b1, 32'h1100_0004, 32'h0, 400, -1);
			check(s_rdata, 32'ha5a5_0000 + d, "read back");
			slv_rty = 1'b1;
			sys_op(1'b0, 32'h1100_0004, 32'hdead_0000, 400, -1);
			slv_rty = 1'b0;
			check(code, 1, "retry answer");
			sys_op(1'b1, 32'h1100_0004, 32'h0, 400, -1);
			check(s_rdata, 32'ha5a5_0000 + d, "retried write not stored");
		end
		// just below the forwarded range: no local strobe, watchdog ends it
		n0 = strobes;
		sys_op(1'b1, 32'h10ff_fffc, 32'h0, 400, -1);
		check(code, 2, "below range answer");
		check(cyc >= 255 && cyc <= 258, 1'b1, "watchdog span");
		check(strobes, n0, "no strobe below range");
		sys_op(1'b0, 32'hffff_fffc, 32'h1, 400, -1);
		check(code, 2, "unanswered top address");
		check(strobes, n0 + 1, "top address forwarded");
		sys_op(1'b1, 32'h10ff_fffc, 32'h0, 300, 10);
		check(code, 3, "other responder stops watchdog");
		user_op(1'b0, 32'h1100_0008, 32'h1234_5678);
		check(u_retried, 1'b0, "peripheral write ended by ready");
		sys_op(1'b1, 32'h1100_0008, 32'h0, 400, -1);
		check(s_rdata, 32'h1234_5678, "peripheral write seen by converter");
		// hold request arrives while a converter write is open
		fork
			sys_op(1'b0, 32'h1100_000c, 32'h0bad_0001, 400, -1);
			user_op(1'b1, 32'h1100_0004, 32'h0);
		join
		check(code, 0, "open write finished before grant");
		check(u_rdata, 32'ha5a5_0001, "peripheral read data");
		slv_rty = 1'b1;
		user_op(1'b0, 32'h1100_0010, 32'h5);
		slv_rty = 1'b0;
		check(u_retried, 1'b1, "peripheral sees retry");
		sys_op(1'b1, 32'h1100_000c, 32'h0, 400, -1);
		check(s_rdata, 32'h0bad_0001, "write held until ready");
		// top lane disabled: it keeps the old byte
		s_be_n = 4'h8;
		sys_op(1'b0, 32'h1100_000c, 32'hffff_ffff, 400, -1);
		s_be_n = 4'h0;
		sys_op(1'b1, 32'h1100_000c, 32'h0, 400, -1);
		check(s_rdata, 32'h0bff_ffff, "byte enables passed");
		complete_run();
	end
endmodule : test_bus_converter
